/* rtl/lsd_drive_cell.sv */
// drive level of one common or segment pin for the current polarity and bias
`default_nettype none
`include "lsd_regs.svh"
module lsd_drive_cell (
   input  wire logic              is_com,
   input  wire logic              active,
   input  wire logic              pol,
   input  wire logic [1:0]        bias,
   output lsd_pkg::lsd_level_t    level
);
   lsd_pkg::lsd_level_t full_hi;
   lsd_pkg::lsd_level_t full_lo;

   assign full_hi = pol ? `LSD_LVL_V3 : `LSD_LVL_V0;
   assign full_lo = pol ? `LSD_LVL_V0 : `LSD_LVL_V3;

   always_comb begin
      case (bias)
         lsd_pkg::LSD_BIAS_STATIC: begin
            level = (is_com || !active) ? full_hi : full_lo;
         end
         lsd_pkg::LSD_BIAS_HALF: begin
            if (is_com) begin
               level = active ? full_hi : `LSD_LVL_V1;
            end else begin
               level = active ? full_lo : full_hi;
            end
         end
         default: begin
            if (is_com) begin
               level = active ? full_hi : (pol ? `LSD_LVL_V1 : `LSD_LVL_V2);
            end else begin
               level = active ? full_lo : (pol ? `LSD_LVL_V2 : `LSD_LVL_V1);
            end
         end
      endcase
   end
endmodule // lsd_drive_cell
`default_nettype wire

/* rtl/lsd_panel_driver.sv */
// panel driver top: register file on AXI4-Lite, frame sequencer and pin drive stage
`default_nettype none
`include "lsd_regs.svh"
module lsd_panel_driver #(
   parameter lsd_pkg::lsd_variant_e VARIANT = lsd_pkg::LSD_VAR_LARGE
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        ce,
   input  wire logic [2:0]  src_tick,
   input  wire logic        sleep_mode,
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   output logic [3:0][1:0]  com_level,
   output logic [3:0]       com_drive_en,
   output logic [41:0][1:0] seg_level,
   output logic [41:0]      seg_drive_en
);
   localparam bit SMALL  = (VARIANT == lsd_pkg::LSD_VAR_SMALL);
   localparam bit LARGE  = (VARIANT == lsd_pkg::LSD_VAR_LARGE);
   localparam int NSEG   = SMALL ? 16 : (LARGE ? 42 : 24);
   localparam int NSE    = SMALL ? 2 : (LARGE ? 6 : 3);
   localparam int NPIXSP = LARGE ? 24 : 12;
   localparam logic [2:0] K_NONE  = 3'h0;
   localparam logic [2:0] K_CTRL  = 3'h1;
   localparam logic [2:0] K_PHASE = 3'h2;
   localparam logic [2:0] K_STAT  = 3'h3;
   localparam logic [2:0] K_SE    = 3'h4;
   localparam logic [2:0] K_PIX   = 3'h5;

   logic [7:0]        ctrl_q;
   logic [7:0]        phase_q;
   logic [5:0][7:0]   se_q;
   logic [23:0][7:0]  pix_q;
   logic [7:0]        aw_addr_q;
   logic [7:0]        w_data_q;
   logic              w_strb0_q;

   lsd_pkg::lsd_seq_e seq_state;
   lsd_pkg::lsd_seq_e next_seq_state;
   logic [1:0]        com_idx;
   logic              pol;
   logic              frame_tog;
   logic [3:0][41:0]  shadow;
   logic [3:0][41:0]  live_pix;
   logic [41:0]       se_bits;

   function automatic logic [2:0] reg_kind(input logic [7:0] a);
      return (a[1:0] != 2'b00)                               ? K_NONE :
             (a == `LSD_OFF_CTRL)                             ? K_CTRL :
             (a == `LSD_OFF_PHASE)                            ? K_PHASE :
             (a == `LSD_OFF_STATUS)                           ? K_STAT :
             (a >= `LSD_OFF_SE_BASE && a < `LSD_OFF_SE_END)   ? K_SE :
             (a >= `LSD_OFF_PIX_BASE && a < `LSD_OFF_PIX_END) ? K_PIX : K_NONE;
   endfunction
   function automatic logic [2:0] se_index(input logic [7:0] a);
      return 3'((a - `LSD_OFF_SE_BASE) >> 2);
   endfunction
   function automatic logic [4:0] pix_index(input logic [7:0] a);
      return 5'((a - `LSD_OFF_PIX_BASE) >> 2);
   endfunction
   // unimplemented registers of smaller variants read zero and ignore writes
   function automatic logic reg_impl(input logic [2:0] k, input logic [7:0] a);
      return (k == K_SE)  ? (int'(se_index(a)) < NSE) :
             (k == K_PIX) ? ((int'(pix_index(a)) < NPIXSP) &&
                             !(SMALL && (pix_index(a) % 5'd3 == 5'd2))) : 1'b1;
   endfunction

   logic [2:0] wk;
   logic       w_impl;
   logic       do_write;
   logic [2:0] rk;
   logic       r_impl;
   logic [7:0] rd_byte;
   logic [7:0] status_w;
   logic [2:0] w_se;
   logic [4:0] w_px;
   logic       wr_ok;

   assign wk       = reg_kind(aw_addr_q);
   assign w_impl   = reg_impl(wk, aw_addr_q);
   assign w_se     = se_index(aw_addr_q);
   assign w_px     = pix_index(aw_addr_q);
   assign do_write = !awready && !wready && !bvalid;
   assign wr_ok    = do_write && w_strb0_q && w_impl;
   assign rk       = reg_kind(araddr);
   assign r_impl   = reg_impl(rk, araddr);

   assign status_w = {seq_state == lsd_pkg::LSD_SEQ_RUN, seq_state == lsd_pkg::LSD_SEQ_HALT,
                      2'b00, frame_tog, pol, com_idx};
   assign rd_byte  = (rk == K_CTRL)            ? ctrl_q :
                     (rk == K_PHASE)           ? phase_q :
                     (rk == K_STAT)            ? status_w :
                     (rk == K_SE  && r_impl)   ? se_q[se_index(araddr)] :
                     (rk == K_PIX && r_impl)   ? pix_q[pix_index(araddr)] : 8'h00;

   // address and data may arrive in either order; each is held until the response is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready   <= 1'b1;
         wready    <= 1'b1;
         bvalid    <= 1'b0;
         bresp     <= `LSD_RESP_OKAY;
         aw_addr_q <= 8'h00;
         w_data_q  <= 8'h00;
         w_strb0_q <= 1'b0;
      end else if (ce) begin
         if (awvalid && awready) begin
            aw_addr_q <= awaddr;
            awready   <= 1'b0;
         end
         if (wvalid && wready) begin
            w_data_q  <= wdata[7:0];
            w_strb0_q <= wstrb[0];
            wready    <= 1'b0;
         end
         if (do_write) begin
            bvalid <= 1'b1;
            bresp  <= (wk == K_NONE) ? `LSD_RESP_SLVERR : `LSD_RESP_OKAY;
         end
         if (bvalid && bready) begin
            bvalid  <= 1'b0;
            awready <= 1'b1;
            wready  <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b1;
         rvalid  <= 1'b0;
         rdata   <= 32'h0000_0000;
         rresp   <= `LSD_RESP_OKAY;
      end else if (ce) begin
         if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= {24'h00_0000, rd_byte};
            rresp   <= (rk == K_NONE) ? `LSD_RESP_SLVERR : `LSD_RESP_OKAY;
         end
         if (rvalid && rready) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q  <= `LSD_CTRL_RST;
         phase_q <= `LSD_PHASE_RST;
         se_q    <= {6{`LSD_SE_RST}};
         pix_q   <= {24{`LSD_PIX_RST}};
      end else if (ce && wr_ok) begin
         if (wk == K_CTRL) begin
            ctrl_q <= w_data_q;
         end
         if (wk == K_PHASE) begin
            phase_q <= w_data_q;
         end
         if (wk == K_SE) begin
            // last enable register only holds segments 41:40
            se_q[w_se] <= (w_se == 3'd5) ? (w_data_q & `LSD_SE_LAST_MASK) : w_data_q;
         end
         if (wk == K_PIX) begin
            pix_q[w_px] <= w_data_q;
         end
      end
   end

   logic        mod_on;
   logic        sleep_stop;
   logic [1:0]  clk_src;
   logic [1:0]  mux_sel;
   logic [1:0]  bias_sel;
   logic [3:0]  prescale;
   logic        wave_b;
   logic        halt_req;
   logic        running;
   logic        step;
   logic        last_com;
   logic        frame_end;
   logic        segment_line_15_lost;

   assign mod_on     = ctrl_q[`LSD_CTRL_ON_BIT];
   assign sleep_stop = ctrl_q[`LSD_CTRL_SLP_BIT];
   assign clk_src    = ctrl_q[`LSD_CTRL_CS_LSB +: 2];
   assign mux_sel    = ctrl_q[`LSD_CTRL_MUX_LSB +: 2];
   assign bias_sel   = ctrl_q[`LSD_CTRL_BIAS_LSB +: 2];
   assign prescale   = phase_q[`LSD_PH_PS_LSB +: 4];
   assign wave_b     = phase_q[`LSD_PH_WAVE_BIT];
   assign halt_req   = sleep_mode && sleep_stop;
   assign running    = (seq_state == lsd_pkg::LSD_SEQ_RUN);
   // a mux change mid-frame must not strand the common index beyond the new count
   assign last_com   = (com_idx >= mux_sel);
   assign frame_end  = step && last_com && pol;
   assign segment_line_15_lost = SMALL && (mux_sel == lsd_pkg::LSD_MUX_QUARTER);

   lsd_tick_div u_tick (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .ce       (ce),
      .run      (running),
      .src_tick (src_tick),
      .src_sel  (clk_src),
      .ratio    (prescale),
      .step     (step)
   );

   always_comb begin
      case (seq_state)
         lsd_pkg::LSD_SEQ_OFF: begin
            next_seq_state = (mod_on && !halt_req) ? lsd_pkg::LSD_SEQ_RUN : seq_state;
         end
         lsd_pkg::LSD_SEQ_RUN: begin
            if (!mod_on) begin
               next_seq_state = lsd_pkg::LSD_SEQ_OFF;
            end else if (halt_req) begin
               next_seq_state = lsd_pkg::LSD_SEQ_HALT;
            end else begin
               next_seq_state = seq_state;
            end
         end
         lsd_pkg::LSD_SEQ_HALT: begin
            if (!mod_on) begin
               next_seq_state = lsd_pkg::LSD_SEQ_OFF;
            end else if (!halt_req) begin
               next_seq_state = lsd_pkg::LSD_SEQ_RUN;
            end else begin
               next_seq_state = seq_state;
            end
         end
         default: begin
            next_seq_state = lsd_pkg::LSD_SEQ_OFF;
         end
      endcase
   end

   // type A flips polarity inside each common slot, type B once per pass over the commons
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         seq_state <= lsd_pkg::LSD_SEQ_OFF;
         com_idx   <= 2'h0;
         pol       <= 1'b0;
         frame_tog <= 1'b0;
      end else if (ce) begin
         seq_state <= next_seq_state;
         if (seq_state == lsd_pkg::LSD_SEQ_OFF) begin
            com_idx <= 2'h0;
            pol     <= 1'b0;
         end else if (running && step) begin
            if (frame_end) begin
               frame_tog <= !frame_tog;
            end
            if (!wave_b) begin
               pol <= !pol;
               if (pol) begin
                  com_idx <= last_com ? 2'h0 : com_idx + 2'h1;
               end
            end else begin
               com_idx <= last_com ? 2'h0 : com_idx + 2'h1;
               if (last_com) begin
                  pol <= !pol;
               end
            end
         end
      end
   end

   // pixel data is copied only at a frame boundary or while the sequencer is off
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         shadow <= '0;
      end else if (ce && (seq_state == lsd_pkg::LSD_SEQ_OFF || frame_end)) begin
         shadow <= live_pix;
      end
   end

   for (genvar s = 0; s < 42; s++) begin : g_se
      assign se_bits[s] = se_q[s / 8][s % 8];
   end

   for (genvar c = 0; c < 4; c++) begin : g_map
      for (genvar s = 0; s < 42; s++) begin : g_seg
         localparam int PI = (s < 24) ? c * 3 + s / 8 : 12 + c * 3 + (s - 24) / 8;
         localparam int PB = (s < 24) ? s % 8 : (s - 24) % 8;
         if (s < NSEG) begin : g_on
            assign live_pix[c][s] = pix_q[PI][PB];
         end else begin : g_off
            assign live_pix[c][s] = 1'b0;
         end
      end
   end

   for (genvar c = 0; c < 4; c++) begin : g_com
      lsd_pkg::lsd_level_t lvl;
      lsd_drive_cell u_cell (
         .is_com (1'b1),
         .active (com_idx == 2'(c)),
         .pol    (pol),
         .bias   (bias_sel),
         .level  (lvl)
      );
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            com_level[c]    <= `LSD_LVL_V0;
            com_drive_en[c] <= 1'b0;
         end else if (ce) begin
            com_level[c]    <= (running && (2'(c) <= mux_sel)) ? lvl : `LSD_LVL_V0;
            com_drive_en[c] <= running && (2'(c) <= mux_sel);
         end
      end
   end

   for (genvar s = 0; s < 42; s++) begin : g_pin
      lsd_pkg::lsd_level_t lvl;
      logic                usable;
      assign usable = (s < NSEG) && se_bits[s] && !(s == 15 && segment_line_15_lost);
      lsd_drive_cell u_cell (
         .is_com (1'b0),
         .active (shadow[com_idx][s]),
         .pol    (pol),
         .bias   (bias_sel),
         .level  (lvl)
      );
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            seg_level[s]    <= `LSD_LVL_V0;
            seg_drive_en[s] <= 1'b0;
         end else if (ce) begin
            seg_level[s]    <= (running && usable) ? lvl : `LSD_LVL_V0;
            seg_drive_en[s] <= running && usable;
         end
      end
   end
endmodule // lsd_panel_driver
`default_nettype wire

/* rtl/lsd_pkg.sv */
// types shared by the panel driver modules
`default_nettype none
package lsd_pkg;
   typedef enum logic [1:0] {
      LSD_MUX_STATIC  = 2'b00,
      LSD_MUX_HALF    = 2'b01,
      LSD_MUX_THIRD   = 2'b10,
      LSD_MUX_QUARTER = 2'b11
   } lsd_mux_e;
   typedef enum logic [1:0] {
      LSD_BIAS_STATIC = 2'b00,
      LSD_BIAS_HALF   = 2'b01,
      LSD_BIAS_THIRD  = 2'b10
   } lsd_bias_e;
   typedef enum logic [1:0] {
      LSD_VAR_SMALL = 2'b00,
      LSD_VAR_MID   = 2'b01,
      LSD_VAR_LARGE = 2'b10
   } lsd_variant_e;
   typedef enum logic [1:0] {
      LSD_SEQ_OFF  = 2'b00,
      LSD_SEQ_RUN  = 2'b01,
      LSD_SEQ_HALT = 2'b10
   } lsd_seq_e;
   typedef logic [1:0] lsd_level_t;
endpackage
`default_nettype wire

/* rtl/lsd_regs.svh */
// register offsets, field positions, reset values and level codes of the panel driver
`ifndef LSD_REGS_SVH
`define LSD_REGS_SVH

`define LSD_OFF_CTRL      8'h00
`define LSD_OFF_PHASE     8'h04
`define LSD_OFF_STATUS    8'h08
`define LSD_OFF_SE_BASE   8'h10
`define LSD_OFF_SE_END    8'h28
`define LSD_OFF_PIX_BASE  8'h40
`define LSD_OFF_PIX_END   8'hA0

`define LSD_CTRL_CS_LSB   0
`define LSD_CTRL_MUX_LSB  2
`define LSD_CTRL_BIAS_LSB 4
`define LSD_CTRL_SLP_BIT  6
`define LSD_CTRL_ON_BIT   7
`define LSD_PH_PS_LSB     0
`define LSD_PH_WAVE_BIT   7
`define LSD_SE_LAST_MASK  8'h03

`define LSD_ST_RUN_BIT    7
`define LSD_ST_HALT_BIT   6
`define LSD_ST_FRAME_BIT  3
`define LSD_ST_POL_BIT    2
`define LSD_ST_COM_LSB    0

`define LSD_CTRL_RST      8'h00
`define LSD_PHASE_RST     8'h00
`define LSD_SE_RST        8'h00
`define LSD_PIX_RST       8'h00

`define LSD_CS_NONE       2'h3
`define LSD_LVL_V0        2'h0
`define LSD_LVL_V1        2'h1
`define LSD_LVL_V2        2'h2
`define LSD_LVL_V3        2'h3

`define LSD_RESP_OKAY     2'b00
`define LSD_RESP_SLVERR   2'b10

`endif

/* rtl/lsd_tick_div.sv */
// clock source selection and programmable prescaler producing frame step pulses
`default_nettype none
`include "lsd_regs.svh"
module lsd_tick_div (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       ce,
   input  wire logic       run,
   input  wire logic [2:0] src_tick,
   input  wire logic [1:0] src_sel,
   input  wire logic [3:0] ratio,
   output logic            step
);
   logic [3:0] count;
   logic       sel_tick;

   assign sel_tick = (src_sel == `LSD_CS_NONE) ? 1'b0 : src_tick[src_sel];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count <= 4'h0;
         step  <= 1'b0;
      end else if (ce) begin
         step <= 1'b0;
         if (!run) begin
            count <= 4'h0;
         end else if (sel_tick) begin
            if (count >= ratio) begin
               count <= 4'h0;
               step  <= 1'b1;
            end else begin
               count <= count + 4'h1;
            end
         end
      end
   end
endmodule // lsd_tick_div
`default_nettype wire

/* verification/lsd_panel_driver_bench.sv */
// self-checking bench of the panel driver with a panel load model
`default_nettype none
`include "lsd_regs.svh"
`define CHECK(got, exp) begin tests_run++; if ((got) !== (exp)) begin bad_count++; \
   $display("Error at %0t: got %0h expected %0h", $time, (got), (exp)); end end
module lsd_panel_driver_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk, aresetn, ce, sleep_mode, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid;
   logic [2:0]        src_tick = 3'b001;
   logic [7:0]        awaddr, araddr;
   logic [31:0]       wdata, rdata;
   logic [3:0]        wstrb, com_drive_en;
   logic [1:0]        bresp, rresp;
   logic [3:0][1:0]   com_level;
   logic [41:0][1:0]  seg_level;
   logic [41:0]       seg_drive_en;
   logic [3:0][41:0]  dark;
   int                bad_count, tests_run;
   lsd_panel_driver u_dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .src_tick(src_tick),
      .sleep_mode(sleep_mode), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .com_level(com_level), .com_drive_en(com_drive_en), .seg_level(seg_level),
      .seg_drive_en(seg_drive_en));
   lsd_panel_model u_panel (.com_level(com_level), .com_drive_en(com_drive_en),
      .seg_level(seg_level), .seg_drive_en(seg_drive_en), .dark(dark));
   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end
   // each source strobes every third cycle, staggered
   always @(posedge aclk) src_tick <= {src_tick[1:0], src_tick[2]};
   task automatic report_and_stop;
      if (bad_count == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic tick(ref int n);
      n++;
      if (n > 200) begin
         bad_count++;
         $display("Error at %0t: wait timed out", $time);
         report_and_stop();
      end
   endtask
   // bready and rready stay high all run, so an answer is taken at the edge where it is seen
   task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
      int   n;
      logic done;
      n = 0;
      done = 1'b0;
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= {24'h000000, d};
      wvalid <= 1'b1;
      while (!done) begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) begin
            r = bresp;
            done = 1'b1;
         end
         tick(n);
      end
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
      int   n;
      logic done;
      n = 0;
      done = 1'b0;
      araddr <= a;
      arvalid <= 1'b1;
      while (!done) begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) begin
            `CHECK(rdata, {24'h000000, e})
            `CHECK(rresp, er)
            done = 1'b1;
         end
         tick(n);
      end
   endtask
   task automatic wr_chk(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
      logic [1:0] r;
      wr(a, d, r);
      `CHECK(r, er)
   endtask
   task automatic wait_com(input logic [3:0] e);
      int n;
      n = 0;
      while (com_drive_en !== e) begin
         @(posedge aclk);
         tick(n);
      end
      `CHECK(com_drive_en, e)
   endtask
   task automatic t_reset;
      rd_chk(`LSD_OFF_CTRL, `LSD_CTRL_RST, `LSD_RESP_OKAY);
      rd_chk(`LSD_OFF_PHASE, `LSD_PHASE_RST, `LSD_RESP_OKAY);
      rd_chk(`LSD_OFF_SE_BASE + 8'h14, `LSD_SE_RST, `LSD_RESP_OKAY);
      rd_chk(`LSD_OFF_PIX_BASE + 8'h5C, `LSD_PIX_RST, `LSD_RESP_OKAY);
      `CHECK(seg_drive_en, 42'h0)
   endtask
   task automatic t_regs;
      wr_chk(`LSD_OFF_SE_BASE + 8'h14, 8'hFF, `LSD_RESP_OKAY);
      rd_chk(`LSD_OFF_SE_BASE + 8'h14, 8'h03, `LSD_RESP_OKAY);
      wr_chk(`LSD_OFF_SE_BASE + 8'h14, 8'h00, `LSD_RESP_OKAY);
      wr_chk(`LSD_OFF_PIX_BASE + 8'h5C, 8'hA5, `LSD_RESP_OKAY);
      rd_chk(`LSD_OFF_PIX_BASE + 8'h5C, 8'hA5, `LSD_RESP_OKAY);
      wr_chk(`LSD_OFF_PHASE, 8'h83, `LSD_RESP_OKAY);
      rd_chk(`LSD_OFF_PHASE, 8'h83, `LSD_RESP_OKAY);
      wr_chk(8'h3C, 8'h55, `LSD_RESP_SLVERR);
      rd_chk(8'h3C, 8'h00, `LSD_RESP_SLVERR);
      wr_chk(`LSD_OFF_PHASE, 8'h00, `LSD_RESP_OKAY);
   endtask
   task automatic t_static;
      logic [1:0] r;
      wr(`LSD_OFF_SE_BASE, 8'h0F, r);
      wr(`LSD_OFF_PIX_BASE, 8'h05, r);
      wr_chk(`LSD_OFF_CTRL, 8'h80, `LSD_RESP_OKAY);
      wait_com(4'h1);
      repeat (2) @(posedge aclk);
      `CHECK(seg_drive_en, 42'h0F)
      `CHECK(dark[0][3:0], 4'b0101)
      wr(`LSD_OFF_PIX_BASE, 8'h0A, r);
      // a static frame lasts six cycles here, so this spans several frames
      repeat (20) @(posedge aclk);
      `CHECK(dark[0][3:0], 4'b1010)
   endtask
   task automatic t_sleep;
      sleep_mode <= 1'b1;
      repeat (20) @(posedge aclk);
      `CHECK(com_drive_en, 4'h1)
      wr_chk(`LSD_OFF_CTRL, 8'hC0, `LSD_RESP_OKAY);
      repeat (20) @(posedge aclk);
      `CHECK(seg_drive_en, 42'h0)
      sleep_mode <= 1'b0;
      wait_com(4'h1);
      wr_chk(`LSD_OFF_CTRL, 8'h00, `LSD_RESP_OKAY);
      wait_com(4'h0);
   endtask
   task automatic t_mux;
      int n;
      for (int m = 0; m < 4; m++) begin
         wr_chk(`LSD_OFF_CTRL, {4'hA, m[1:0], m[1:0]}, `LSD_RESP_OKAY);
         wait_com(4'((1 << (m + 1)) - 1));
      end
      wr_chk(`LSD_OFF_PHASE, 8'h80, `LSD_RESP_OKAY);
      for (int b = 1; b < 3; b++) begin
         wr_chk(`LSD_OFF_CTRL, {2'b10, b[1:0], 4'hC}, `LSD_RESP_OKAY);
         repeat (5) @(posedge aclk);
         n = 0;
         for (int c = 0; c < 4; c++) n += (com_level[c] inside {2'h0, 2'h3}) ? 1 : 0;
         `CHECK(n, 1)
      end
      wr_chk(`LSD_OFF_CTRL, 8'h00, `LSD_RESP_OKAY);
   endtask
   initial begin
      {aresetn, sleep_mode, awvalid, wvalid, arvalid} = '0;
      {bready, rready} = 2'b11;
      ce = 1'b1;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0;
      wstrb = 4'hF;
      bad_count = 0;
      tests_run = 0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_reset();
      t_regs();
      t_static();
      t_sleep();
      t_mux();
      report_and_stop();
   end
endmodule // lsd_panel_driver_bench
`default_nettype wire

/* verification/lsd_panel_driver_props.sv */
// bus handshake and pin drive assertions for the panel driver
`default_nettype none
module lsd_panel_props #(
   parameter lsd_pkg::lsd_variant_e VARIANT = lsd_pkg::LSD_VAR_LARGE
) (
   input wire logic              aclk,
   input wire logic              aresetn,
   input wire logic              ce,
   input wire logic              awvalid,
   input wire logic              awready,
   input wire logic              wvalid,
   input wire logic              wready,
   input wire logic [1:0]        bresp,
   input wire logic              bvalid,
   input wire logic              bready,
   input wire logic              arvalid,
   input wire logic              arready,
   input wire logic [31:0]       rdata,
   input wire logic [1:0]        rresp,
   input wire logic              rvalid,
   input wire logic              rready,
   input wire logic [3:0][1:0]   com_level,
   input wire logic [3:0]        com_drive_en,
   input wire logic [41:0][1:0]  seg_level,
   input wire logic [41:0]       seg_drive_en
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int SEG_COUNT = (VARIANT == lsd_pkg::LSD_VAR_SMALL) ? 16 :
                              (VARIANT == lsd_pkg::LSD_VAR_MID) ? 24 : 42;
   logic [41:0] seg_nz;
   logic [3:0]  com_nz;
   always_comb begin
      for (int i = 0; i < 42; i++) seg_nz[i] = |seg_level[i];
      for (int i = 0; i < 4; i++) com_nz[i] = |com_level[i];
   end
   // a frozen clock enable holds every flop, so nothing is judged meanwhile
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn || !ce);
   property p_b_after_w;
      (awvalid && awready && wvalid && wready) |-> ##2 bvalid;
   endproperty
   a_b_after_w: assert property (p_b_after_w) else $error("write response late");
   property p_r_after_ar;
      (arvalid && arready) |=> (rvalid && !arready);
   endproperty
   a_r_after_ar: assert property (p_r_after_ar) else $error("read response late");
   property p_b_stands;
      (bvalid && !bready) |=> (bvalid && $stable(bresp));
   endproperty
   a_b_stands: assert property (p_b_stands) else $error("write response dropped");
   property p_r_stands;
      (rvalid && !rready) |=> (rvalid && $stable(rdata) && $stable(rresp));
   endproperty
   a_r_stands: assert property (p_r_stands) else $error("read response dropped");
   property p_wr_blocked;
      bvalid |-> (!awready && !wready);
   endproperty
   a_wr_blocked: assert property (p_wr_blocked) else $error("write taken during response");
   property p_rdata_byte;
      rvalid |-> (rdata[31:8] == 24'h000000);
   endproperty
   a_rdata_byte: assert property (p_rdata_byte) else $error("upper read bits set");
   property p_seg_release;
      (seg_nz & ~seg_drive_en) == 42'h0;
   endproperty
   a_seg_release: assert property (p_seg_release) else $error("idle segment level");
   property p_com_release;
      (com_nz & ~com_drive_en) == 4'h0;
   endproperty
   a_com_release: assert property (p_com_release) else $error("idle common level");
   property p_seg_count;
      (seg_drive_en >> SEG_COUNT) == 42'h0;
   endproperty
   a_seg_count: assert property (p_seg_count) else $error("segment past variant");
   property p_com_contig;
      com_drive_en inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hF};
   endproperty
   a_com_contig: assert property (p_com_contig) else $error("common set broken");
   property p_seg_with_com;
      (|seg_drive_en) |-> (|com_drive_en);
   endproperty
   a_seg_with_com: assert property (p_seg_with_com) else $error("segments alone");
endmodule // lsd_panel_props
bind lsd_panel_driver lsd_panel_props #(.VARIANT(VARIANT)) u_props (
   .aclk(aclk), .aresetn(aresetn), .ce(ce), .awvalid(awvalid), .awready(awready),
   .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
   .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
   .rready(rready), .com_level(com_level), .com_drive_en(com_drive_en),
   .seg_level(seg_level), .seg_drive_en(seg_drive_en));
`default_nettype wire

/* verification/lsd_panel_model.sv */
// panel load model: a pixel darkens when common and segment sit at opposite full levels
`default_nettype none
module lsd_panel_model (
   input  wire logic [3:0][1:0]  com_level,
   input  wire logic [3:0]       com_drive_en,
   input  wire logic [41:0][1:0] seg_level,
   input  wire logic [41:0]      seg_drive_en,
   output logic [3:0][41:0]      dark
);
   timeunit 1ns;
   timeprecision 1ps;
   // a released pin floats, so it can never darken a pixel
   always_comb begin
      for (int c = 0; c < 4; c++) begin
         for (int s = 0; s < 42; s++) begin
            dark[c][s] = com_drive_en[c] && seg_drive_en[s] &&
               ((com_level[c] == 2'h0 && seg_level[s] == 2'h3) ||
                (com_level[c] == 2'h3 && seg_level[s] == 2'h0));
         end
      end
   end
endmodule // lsd_panel_model
`default_nettype wire
